// >>> rtl/bcu_regs.svh
`ifndef BCU_REGS_SVH
`define BCU_REGS_SVH

`define BCU_OP_SPECIAL 6'h00
`define BCU_OP_REGIMM 6'h01
`define BCU_OP_UNEQ 6'h05
`define BCU_OP_NONPOS 6'h06
`define BCU_OP_UNEQ_L 6'h15
`define BCU_OP_NONPOS_L 6'h16
`define BCU_OP_POS_L 6'h17
`define BCU_FN_TRAP 6'h0d
`define BCU_RI_NEG 5'h00
`define BCU_RI_NEG_L 5'h02
`define BCU_RI_NEG_LINK 5'h10
`define BCU_RI_NEG_LINK_L 5'h12
`define BCU_ZERO_FIELD 5'h00
`define BCU_LINK_REG 5'h1f
`define BCU_SLOT_STEP 32'h0000_0004
`define BCU_LINK_STEP 32'h0000_0008
`define BCU_RST_PC 32'h0000_0000

`endif

// >>> rtl/bcu_pkg.sv
package bcu_pkg;

	typedef enum logic [3:0] {
		BCU_K_NONE,
		BCU_K_POS_L,
		BCU_K_NONPOS,
		BCU_K_NONPOS_L,
		BCU_K_NEG,
		BCU_K_NEG_L,
		BCU_K_NEG_LINK,
		BCU_K_NEG_LINK_L,
		BCU_K_UNEQ,
		BCU_K_UNEQ_L,
		BCU_K_TRAP
	} bcu_kind_e;

	typedef enum logic [0:0] {
		BCU_S_IDLE,
		BCU_S_EVAL
	} bcu_state_e;

	typedef logic [31:0] bcu_word_t;

	typedef struct packed {
		bcu_state_e state;
		bcu_kind_e kind;
		bcu_word_t pc;
		logic [15:0] offset;
		logic [4:0] src_a_idx;
		logic [4:0] src_b_idx;
		logic ready;
		logic redirect_valid;
		bcu_word_t redirect_pc;
		logic nullify_slot;
		logic link_we;
		bcu_word_t link_data;
		logic trap_valid;
		bcu_word_t debug_return_pc;
		logic done;
	} bcu_state_s;

endpackage : bcu_pkg

// >>> rtl/bcu_cond.sv
`timescale 1ns/10ps
module bcu_cond (
	input wire bcu_pkg::bcu_kind_e kind,
	input wire logic [31:0] src_a,
	input wire logic [31:0] src_b,
	output logic take,
	output logic likely
);
	logic a_zero;

	assign a_zero = (src_a == 32'h0000_0000);

	always_comb
	begin
		take = 1'b0;
		likely = 1'b0;
		case (kind)
			bcu_pkg::BCU_K_POS_L:
			begin
				take = !src_a[31] && !a_zero; // [RULE_04]
				likely = 1'b1;
			end
			bcu_pkg::BCU_K_NONPOS:
			begin
				take = src_a[31] || a_zero; // [RULE_05]
			end
			bcu_pkg::BCU_K_NONPOS_L:
			begin
				take = src_a[31] || a_zero; // [RULE_05]
				likely = 1'b1;
			end
			bcu_pkg::BCU_K_NEG, bcu_pkg::BCU_K_NEG_LINK:
			begin
				take = src_a[31]; // [RULE_06]
			end
			bcu_pkg::BCU_K_NEG_L, bcu_pkg::BCU_K_NEG_LINK_L:
			begin
				take = src_a[31]; // [RULE_06]
				likely = 1'b1; // [RULE_03]
			end
			bcu_pkg::BCU_K_UNEQ:
			begin
				take = (src_a != src_b); // [RULE_09]
			end
			bcu_pkg::BCU_K_UNEQ_L:
			begin
				take = (src_a != src_b); // [RULE_09]
				likely = 1'b1;
			end
			default:
			begin
				take = 1'b0;
				likely = 1'b0;
			end
		endcase
	end
endmodule : bcu_cond

// >>> rtl/bcu_top.sv
// Notes on behaviour
// [RULE_01] Target is delay-slot address plus sign-extended offset shifted left two.
// [RULE_02] A taken branch redirects the PC only after the one delay-slot instruction.
// [RULE_03] Every likely form nullifies its delay slot when not taken.
// [RULE_04] Opcode 010111 with zero second field is positive likely: sign clear, nonzero.
// [RULE_05] Opcodes 000110 and 010110 branch when sign set or value zero.
// [RULE_06] Group 000001 codes 00000 and 00010 branch when sign bit set.
// [RULE_07] Codes 10000 and 10010 always write post-slot address into r31.
// [RULE_08] Testing r31 in a link branch is discouraged but raises no error.
// [RULE_09] Opcodes 000101 and 010101 branch when the two registers differ.
// [RULE_10] Special function 001101 raises a breakpoint exception at once.
// [RULE_11] Trap code is ignored; trapping address is kept in the debug return PC.
// [RULE_12] Conditions use forwarded register values, stalling while a load to a tested nonzero register is pending.
`timescale 1ns/10ps
`include "bcu_regs.svh"
module bcu_top (
	input wire logic clk,
	input wire logic srst,
	input wire logic instr_valid,
	input wire logic [31:0] instr_word,
	input wire logic [31:0] instr_pc,
	input wire logic [31:0] rf_a_data,
	input wire logic [31:0] rf_b_data,
	input wire logic fwd_we,
	input wire logic [4:0] fwd_idx,
	input wire logic [31:0] fwd_data,
	input wire logic load_pending,
	input wire logic [4:0] load_idx,
	output logic ready,
	output logic [4:0] src_a_idx,
	output logic [4:0] src_b_idx,
	output logic redirect_valid,
	output logic [31:0] redirect_pc,
	output logic nullify_slot,
	output logic link_we,
	output logic [4:0] link_idx,
	output logic [31:0] link_data,
	output logic trap_valid,
	output logic [31:0] debug_return_pc,
	output logic done
);
	bcu_pkg::bcu_state_s st_q;
	bcu_pkg::bcu_state_s st_d;
	bcu_pkg::bcu_kind_e dec_kind;
	logic [31:0] op_a;
	logic [31:0] op_b;
	logic hazard;
	logic take;
	logic likely;
	logic fire;
	logic [31:0] tgt;

	function automatic logic [31:0] pick(input logic [4:0] idx, input logic [31:0] rf_val,
		input logic we, input logic [4:0] widx, input logic [31:0] wdata);
		logic [31:0] r;
		r = rf_val;
		if (idx == 5'h00)
		begin
			r = 32'h0000_0000;
		end
		else if (we && (widx == idx))
		begin
			r = wdata;
		end
		return r;
	endfunction : pick

	function automatic logic needs_b(input bcu_pkg::bcu_kind_e k);
		return (k == bcu_pkg::BCU_K_UNEQ) || (k == bcu_pkg::BCU_K_UNEQ_L);
	endfunction : needs_b

	function automatic logic is_link(input bcu_pkg::bcu_kind_e k);
		return (k == bcu_pkg::BCU_K_NEG_LINK) || (k == bcu_pkg::BCU_K_NEG_LINK_L);
	endfunction : is_link

	always_comb
	begin
		dec_kind = bcu_pkg::BCU_K_NONE;
		case (instr_word[31:26])
			`BCU_OP_POS_L:
			begin
				if (instr_word[20:16] == `BCU_ZERO_FIELD)
				begin
					dec_kind = bcu_pkg::BCU_K_POS_L; // [RULE_04]
				end
			end
			`BCU_OP_NONPOS:
			begin
				dec_kind = bcu_pkg::BCU_K_NONPOS; // [RULE_05]
			end
			`BCU_OP_NONPOS_L:
			begin
				dec_kind = bcu_pkg::BCU_K_NONPOS_L; // [RULE_05]
			end
			`BCU_OP_REGIMM:
			begin
				case (instr_word[20:16])
					`BCU_RI_NEG: dec_kind = bcu_pkg::BCU_K_NEG; // [RULE_06]
					`BCU_RI_NEG_L: dec_kind = bcu_pkg::BCU_K_NEG_L; // [RULE_06]
					`BCU_RI_NEG_LINK: dec_kind = bcu_pkg::BCU_K_NEG_LINK; // [RULE_07]
					`BCU_RI_NEG_LINK_L: dec_kind = bcu_pkg::BCU_K_NEG_LINK_L; // [RULE_07]
					default: dec_kind = bcu_pkg::BCU_K_NONE;
				endcase
			end
			`BCU_OP_UNEQ:
			begin
				dec_kind = bcu_pkg::BCU_K_UNEQ; // [RULE_09]
			end
			`BCU_OP_UNEQ_L:
			begin
				dec_kind = bcu_pkg::BCU_K_UNEQ_L; // [RULE_09]
			end
			`BCU_OP_SPECIAL:
			begin
				if (instr_word[5:0] == `BCU_FN_TRAP)
				begin
					dec_kind = bcu_pkg::BCU_K_TRAP; // [RULE_10]
				end
			end
			default:
			begin
				dec_kind = bcu_pkg::BCU_K_NONE;
			end
		endcase
	end

	// Operands are the register file values overridden by the newest result in flight.
	assign op_a = pick(st_q.src_a_idx, rf_a_data, fwd_we, fwd_idx, fwd_data); // [RULE_12]
	assign op_b = pick(st_q.src_b_idx, rf_b_data, fwd_we, fwd_idx, fwd_data); // [RULE_12]

	// A load still in flight to a needed register holds evaluation.
	assign hazard = load_pending && (load_idx != 5'h00) && st_q.kind != bcu_pkg::BCU_K_TRAP
		&& ((load_idx == st_q.src_a_idx) || (needs_b(st_q.kind) && load_idx == st_q.src_b_idx));
	assign fire = (st_q.state == bcu_pkg::BCU_S_EVAL) && !hazard; // [RULE_12]

	// Offset shifted by two, sign-extended, added to the delay-slot address.
	assign tgt = st_q.pc + `BCU_SLOT_STEP
		+ {{14{st_q.offset[15]}}, st_q.offset, 2'b00}; // [RULE_01]

	bcu_cond u_cond (
		.kind(st_q.kind),
		.src_a(op_a),
		.src_b(op_b),
		.take(take),
		.likely(likely)
	);

	always_comb
	begin
		st_d = st_q;
		st_d.redirect_valid = 1'b0;
		st_d.nullify_slot = 1'b0;
		st_d.link_we = 1'b0;
		st_d.trap_valid = 1'b0;
		st_d.done = 1'b0;
		case (st_q.state)
			bcu_pkg::BCU_S_IDLE:
			begin
				if (instr_valid && st_q.ready && dec_kind != bcu_pkg::BCU_K_NONE)
				begin
					st_d.state = bcu_pkg::BCU_S_EVAL;
					st_d.kind = dec_kind;
					st_d.pc = instr_pc;
					st_d.offset = instr_word[15:0];
					st_d.src_a_idx = instr_word[25:21];
					st_d.src_b_idx = instr_word[20:16];
					st_d.ready = 1'b0;
				end
			end
			bcu_pkg::BCU_S_EVAL:
			begin
				if (fire)
				begin
					st_d.state = bcu_pkg::BCU_S_IDLE;
					st_d.ready = 1'b1;
					st_d.done = 1'b1;
					if (st_q.kind == bcu_pkg::BCU_K_TRAP)
					begin
						st_d.trap_valid = 1'b1; // [RULE_10]
						st_d.debug_return_pc = st_q.pc; // [RULE_11]
					end
					else
					begin
						// The fetch already holds the slot; the target applies after it.
						st_d.redirect_valid = take; // [RULE_02]
						st_d.redirect_pc = tgt; // [RULE_01]
						st_d.nullify_slot = likely && !take; // [RULE_03]
						if (is_link(st_q.kind))
						begin
							// The test used the value read before this write, even for r31.
							st_d.link_we = 1'b1; // [RULE_07] [RULE_08]
							st_d.link_data = st_q.pc + `BCU_LINK_STEP; // [RULE_07]
						end
					end
				end
			end
			default:
			begin
				st_d.state = bcu_pkg::BCU_S_IDLE;
				st_d.ready = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			st_q <= '0;
			st_q.state <= bcu_pkg::BCU_S_IDLE;
			st_q.kind <= bcu_pkg::BCU_K_NONE;
			st_q.ready <= 1'b1;
			st_q.pc <= `BCU_RST_PC;
			st_q.debug_return_pc <= `BCU_RST_PC;
		end
		else
		begin
			st_q <= st_d;
		end
	end

	assign ready = st_q.ready;
	assign src_a_idx = st_q.src_a_idx;
	assign src_b_idx = st_q.src_b_idx;
	assign redirect_valid = st_q.redirect_valid;
	assign redirect_pc = st_q.redirect_pc;
	assign nullify_slot = st_q.nullify_slot;
	assign link_we = st_q.link_we;
	assign link_idx = `BCU_LINK_REG;
	assign link_data = st_q.link_data;
	assign trap_valid = st_q.trap_valid;
	assign debug_return_pc = st_q.debug_return_pc;
	assign done = st_q.done;

	sequence s_fire_kind(bcu_pkg::bcu_kind_e k);
		fire && st_q.kind == k;
	endsequence

	property p_target;
		@(posedge clk) disable iff (srst)
		fire && take |=> redirect_valid && redirect_pc == $past(tgt)
			&& redirect_pc == $past(st_q.pc) + 32'h0000_0004
			+ {{14{$past(st_q.offset[15])}}, $past(st_q.offset), 2'b00};
	endproperty
	a_target: assert property (p_target) else $error("branch target wrong"); // [RULE_01]

	property p_one_shot;
		@(posedge clk) disable iff (srst)
		redirect_valid |-> $past(fire) ##1 !redirect_valid;
	endproperty
	a_one_shot: assert property (p_one_shot) else $error("redirect not one cycle"); // [RULE_02]

	property p_nullify;
		@(posedge clk) disable iff (srst)
		fire && likely && !take |=> nullify_slot && !redirect_valid;
	endproperty
	a_nullify: assert property (p_nullify) else $error("likely slot not nullified"); // [RULE_03]

	property p_pos_l;
		@(posedge clk) disable iff (srst)
		s_fire_kind(bcu_pkg::BCU_K_POS_L) |=> redirect_valid
			== (!$past(op_a[31]) && $past(op_a) != 32'h0000_0000);
	endproperty
	a_pos_l: assert property (p_pos_l) else $error("positive likely wrong"); // [RULE_04]

	property p_nonpos;
		@(posedge clk) disable iff (srst)
		s_fire_kind(bcu_pkg::BCU_K_NONPOS) |=> redirect_valid
			== ($past(op_a[31]) || $past(op_a) == 32'h0000_0000);
	endproperty
	a_nonpos: assert property (p_nonpos) else $error("nonpositive wrong"); // [RULE_05]

	property p_neg;
		@(posedge clk) disable iff (srst)
		s_fire_kind(bcu_pkg::BCU_K_NEG) |=> redirect_valid == $past(op_a[31]);
	endproperty
	a_neg: assert property (p_neg) else $error("negative wrong"); // [RULE_06]

	property p_link;
		@(posedge clk) disable iff (srst)
		fire && is_link(st_q.kind) |=> link_we && link_idx == 5'h1f
			&& link_data == $past(st_q.pc) + 32'h0000_0008;
	endproperty
	a_link: assert property (p_link) else $error("link write missing"); // [RULE_07]

	property p_r31_ok;
		@(posedge clk) disable iff (srst)
		fire && is_link(st_q.kind) && st_q.src_a_idx == 5'h1f |=> !trap_valid && done;
	endproperty
	a_r31_ok: assert property (p_r31_ok) else $error("r31 test faulted"); // [RULE_08]

	property p_uneq;
		@(posedge clk) disable iff (srst)
		s_fire_kind(bcu_pkg::BCU_K_UNEQ_L) |=> redirect_valid == ($past(op_a) != $past(op_b))
			&& nullify_slot == ($past(op_a) == $past(op_b));
	endproperty
	a_uneq: assert property (p_uneq) else $error("unequal likely wrong"); // [RULE_09]

	property p_trap;
		@(posedge clk) disable iff (srst)
		s_fire_kind(bcu_pkg::BCU_K_TRAP) |=> trap_valid && !redirect_valid
			&& debug_return_pc == $past(st_q.pc);
	endproperty
	a_trap: assert property (p_trap) else $error("trap not raised"); // [RULE_10] [RULE_11]

	property p_stall;
		@(posedge clk) disable iff (srst)
		st_q.state == bcu_pkg::BCU_S_EVAL && hazard |=> !done && !redirect_valid && !ready;
	endproperty
	a_stall: assert property (p_stall) else $error("evaluated during load hazard"); // [RULE_12]
endmodule : bcu_top

// >>> sim/bcu_rf_model.sv
`timescale 1ns/10ps
// Register file of the pipeline: combinational reads, index zero reads as zero.
module bcu_rf_model (
	input wire logic clk,
	input wire logic wr_en,
	input wire logic [4:0] wr_idx,
	input wire logic [31:0] wr_data,
	input wire logic [4:0] rd_a_idx,
	input wire logic [4:0] rd_b_idx,
	output logic [31:0] rd_a_data,
	output logic [31:0] rd_b_data
);
	logic [31:0] regs [32];
	always @(posedge clk)
	begin
		if (wr_en)
		begin
			regs[wr_idx] <= wr_data;
		end
	end
	assign rd_a_data = (rd_a_idx == 5'h00) ? 32'h0000_0000 : regs[rd_a_idx];
	assign rd_b_data = (rd_b_idx == 5'h00) ? 32'h0000_0000 : regs[rd_b_idx];
endmodule : bcu_rf_model

// >>> sim/tb_top.sv
`timescale 1ns/10ps
module tb_top;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic instr_valid = 1'b0;
	logic [31:0] instr_word = 32'h0000_0000;
	logic [31:0] instr_pc = 32'h0000_0000;
	logic [31:0] rf_a_data;
	logic [31:0] rf_b_data;
	logic fwd_we = 1'b0;
	logic [4:0] fwd_idx = 5'h00;
	logic [31:0] fwd_data = 32'h0000_0000;
	logic load_pending = 1'b0;
	logic [4:0] load_idx = 5'h00;
	logic ready, redirect_valid, nullify_slot, link_we, trap_valid, done;
	logic [4:0] src_a_idx, src_b_idx, link_idx;
	logic [31:0] redirect_pc, link_data, debug_return_pc;
	logic wr_en = 1'b0;
	logic [4:0] wr_idx = 5'h00;
	logic [31:0] wr_data = 32'h0000_0000;
	int n_fail = 0;
	int compares = 0;

	always #10 clk = ~clk;

	bcu_top u_bcu_top (.clk(clk), .srst(srst), .instr_valid(instr_valid),
		.instr_word(instr_word), .instr_pc(instr_pc), .rf_a_data(rf_a_data),
		.rf_b_data(rf_b_data), .fwd_we(fwd_we), .fwd_idx(fwd_idx), .fwd_data(fwd_data),
		.load_pending(load_pending), .load_idx(load_idx), .ready(ready),
		.src_a_idx(src_a_idx), .src_b_idx(src_b_idx), .redirect_valid(redirect_valid),
		.redirect_pc(redirect_pc), .nullify_slot(nullify_slot), .link_we(link_we),
		.link_idx(link_idx), .link_data(link_data), .trap_valid(trap_valid),
		.debug_return_pc(debug_return_pc), .done(done));

	bcu_rf_model u_bcu_rf_model (.clk(clk), .wr_en(wr_en), .wr_idx(wr_idx),
		.wr_data(wr_data), .rd_a_idx(src_a_idx), .rd_b_idx(src_b_idx),
		.rd_a_data(rf_a_data), .rd_b_data(rf_b_data));

	task complete_run;
		if (n_fail == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : complete_run

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e)
		begin
			n_fail++;
			$display("wrong value %s expected %0h seen %0h", nm, e, g);
		end
	endtask : chk

	function automatic logic [31:0] e(input logic [5:0] op, input logic [4:0] a,
		input logic [4:0] b, input logic [15:0] off);
		return {op, a, b, off};
	endfunction : e

	task setr(input logic [4:0] idx, input logic [31:0] val);
		@(negedge clk);
		wr_en = 1'b1;
		wr_idx = idx;
		wr_data = val;
		@(negedge clk);
		wr_en = 1'b0;
	endtask : setr

	// Offers one instruction and judges the answer cycle; hold is the stall length.
	task go(input logic [31:0] w, input logic tk, input logic nl, input logic lk,
		input logic tr, input int hold);
		int n;
		logic [31:0] pc;
		pc = {16'h0000, w[15:2], 2'b00} ^ 32'h0040_1000;
		@(negedge clk);
		chk("ready", 32'h1, {31'h0, ready});
		instr_valid = 1'b1;
		instr_word = w;
		instr_pc = pc;
		@(negedge clk);
		instr_valid = 1'b0;
		n = 1;
		chk("ready", 32'h0, {31'h0, ready});
		chk("src_a_idx", {27'h0, w[25:21]}, {27'h0, src_a_idx});
		chk("src_b_idx", {27'h0, w[20:16]}, {27'h0, src_b_idx});
		while (done !== 1'b1 && n < 20)
		begin
			if (n == hold + 1)
				load_pending = 1'b0;
			@(negedge clk);
			n++;
		end
		chk("done", 32'h1, {31'h0, done});
		if (done !== 1'b1)
			complete_run();
		chk("latency", 32'(2 + hold), 32'(n));
		chk("redirect_valid", {31'h0, tk}, {31'h0, redirect_valid});
		chk("nullify_slot", {31'h0, nl}, {31'h0, nullify_slot});
		chk("link_we", {31'h0, lk}, {31'h0, link_we});
		chk("trap_valid", {31'h0, tr}, {31'h0, trap_valid});
		if (tk)
			chk("redirect_pc", pc + 32'h4 + {{14{w[15]}}, w[15:0], 2'b00}, redirect_pc);
		if (lk)
			chk("link_data", pc + 32'h8, link_data);
		if (lk)
			chk("link_idx", 32'h1f, {27'h0, link_idx});
		if (tr)
			chk("debug_return_pc", pc, debug_return_pc);
	endtask : go

	task t_positive;
		go(e(6'h17, 5'd1, 5'd0, 16'h0010), 1, 0, 0, 0, 0);
		go(e(6'h17, 5'd0, 5'd0, 16'h0020), 0, 1, 0, 0, 0);
		go(e(6'h17, 5'd2, 5'd0, 16'h0030), 0, 1, 0, 0, 0);
	endtask : t_positive

	task t_nonpositive;
		go(e(6'h06, 5'd0, 5'd0, 16'h0040), 1, 0, 0, 0, 0);
		go(e(6'h06, 5'd1, 5'd0, 16'h0044), 0, 0, 0, 0, 0);
		go(e(6'h06, 5'd2, 5'd0, 16'hfff0), 1, 0, 0, 0, 0);
		go(e(6'h16, 5'd1, 5'd0, 16'h0048), 0, 1, 0, 0, 0);
		go(e(6'h16, 5'd0, 5'd0, 16'h004c), 1, 0, 0, 0, 0);
	endtask : t_nonpositive

	task t_negative;
		go(e(6'h01, 5'd2, 5'h00, 16'h0050), 1, 0, 0, 0, 0);
		go(e(6'h01, 5'd1, 5'h00, 16'h0054), 0, 0, 0, 0, 0);
		go(e(6'h01, 5'd1, 5'h02, 16'h0058), 0, 1, 0, 0, 0);
		go(e(6'h01, 5'd2, 5'h02, 16'h7fff), 1, 0, 0, 0, 0);
	endtask : t_negative

	task t_link;
		go(e(6'h01, 5'd1, 5'h10, 16'h0060), 0, 0, 1, 0, 0);
		go(e(6'h01, 5'd2, 5'h12, 16'h0064), 1, 0, 1, 0, 0);
		go(e(6'h01, 5'd1, 5'h12, 16'h0068), 0, 1, 1, 0, 0);
		go(e(6'h01, 5'd31, 5'h10, 16'h006c), 1, 0, 1, 0, 0);
	endtask : t_link

	task t_unequal;
		go(e(6'h05, 5'd1, 5'd2, 16'h8000), 1, 0, 0, 0, 0);
		go(e(6'h05, 5'd1, 5'd4, 16'h0070), 0, 0, 0, 0, 0);
		go(e(6'h15, 5'd1, 5'd4, 16'h0074), 0, 1, 0, 0, 0);
		go(e(6'h15, 5'd0, 5'd1, 16'h0078), 1, 0, 0, 0, 0);
	endtask : t_unequal

	task t_trap;
		go({6'h00, 20'hfffff, 6'h0d}, 0, 0, 0, 1, 0);
		go({6'h00, 20'h00010, 6'h0d}, 0, 0, 0, 1, 0);
	endtask : t_trap

	task t_hazard;
		load_pending = 1'b1;
		load_idx = 5'd2;
		go(e(6'h01, 5'd2, 5'h00, 16'h0080), 1, 0, 0, 0, 3);
		load_pending = 1'b1;
		load_idx = 5'd4;
		go(e(6'h05, 5'd1, 5'd4, 16'h0084), 0, 0, 0, 0, 2);
		fwd_we = 1'b1;
		fwd_idx = 5'd1;
		fwd_data = 32'h8000_0001;
		go(e(6'h01, 5'd1, 5'h00, 16'h0088), 1, 0, 0, 0, 0);
		fwd_we = 1'b0;
	endtask : t_hazard

	task t_ignored;
		@(negedge clk);
		instr_valid = 1'b1;
		instr_word = e(6'h02, 5'd1, 5'd0, 16'h0090);
		@(negedge clk);
		instr_word = e(6'h17, 5'd1, 5'd3, 16'h0094);
		@(negedge clk);
		instr_valid = 1'b0;
		repeat (3)
		begin
			chk("done", 32'h0, {31'h0, done});
			chk("ready", 32'h1, {31'h0, ready});
			@(negedge clk);
		end
	endtask : t_ignored

	initial
	begin
		repeat (4) @(negedge clk);
		srst = 1'b0;
		chk("ready", 32'h1, {31'h0, ready});
		chk("debug_return_pc", 32'h0, debug_return_pc);
		setr(5'd1, 32'h0000_0005);
		setr(5'd2, 32'h8000_0000);
		setr(5'd4, 32'h0000_0005);
		setr(5'd31, 32'hffff_fff0);
		t_positive();
		t_nonpositive();
		t_negative();
		t_link();
		t_unequal();
		t_trap();
		t_hazard();
		t_ignored();
		complete_run();
	end
endmodule : tb_top
